/* sss_pkg.sv */
// Package of constants for the serial stretch and sample assist
package sss_pkg;

   // ---------------------------------------------------------------
   // Bus widths
   // ---------------------------------------------------------------
   localparam int AVS_AW = 5;
   localparam int AVS_DW = 32;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [AVS_AW-1:0] OFS_CONTROL   = 5'h00;
   localparam logic [AVS_AW-1:0] OFS_CLOCK     = 5'h04;
   localparam logic [AVS_AW-1:0] OFS_DATA      = 5'h08;
   localparam logic [AVS_AW-1:0] OFS_COND_ONE  = 5'h0c;
   localparam logic [AVS_AW-1:0] OFS_COND_TWO  = 5'h10;
   localparam logic [AVS_AW-1:0] OFS_SAMPLED   = 5'h14;
   localparam logic [AVS_AW-1:0] OFS_EDGE      = 5'h18;
   localparam logic [AVS_AW-1:0] OFS_PULLUP    = 5'h1c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_ENABLE_POS   = 0;
   localparam int CTRL_STRETCH_POS  = 1;
   localparam int CTRL_CONDSTR_POS  = 2;
   localparam int CTRL_ACTIVE_POS   = 3;
   localparam int LINE_BIT_POS      = 0;
   localparam int PULLUP_CLOCK_POS  = 4;
   localparam int PULLUP_DATA_POS   = 5;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_LINE_WRITE = 1'b1;
   localparam logic RST_FLAG       = 1'b0;
   localparam logic RST_LEVEL      = 1'b1;

   // ---------------------------------------------------------------
   // Link events carried across the clock boundary
   // ---------------------------------------------------------------
   localparam int EVT_N     = 4;
   localparam int EVT_RISE  = 0;
   localparam int EVT_FALL  = 1;
   localparam int EVT_COND1 = 2;
   localparam int EVT_COND2 = 3;

endpackage

/* sss_evt_if.sv */
// Interface carrying link events and pin levels between domains
`timescale 1ns/10ps
interface sss_evt_if;
   import sss_pkg::*;

   // Link domain side
   logic [EVT_N-1:0] evt_toggle;
   logic             sample_link;
   logic [1:0]       level_link;
   // System domain side
   logic [EVT_N-1:0] evt_pulse;
   logic             sample_sys;
   logic [1:0]       level_sys;

   modport src  (output evt_toggle, output sample_link, output level_link);
   modport sync (input  evt_toggle, input  sample_link, input  level_link,
                 output evt_pulse,  output sample_sys,  output level_sys);
   modport core (input  evt_pulse,  input  sample_sys,  input  level_sys);
endinterface

/* sss_pin_sampler.sv */
// Link-domain pin synchroniser and edge detector
`timescale 1ns/10ps
module sss_pin_sampler (
   input  wire logic link_clk_in,
   input  wire logic arst_n_in,
   input  wire logic clock_line_in,
   input  wire logic data_line_in,
   sss_evt_if.src    evt
);
   import sss_pkg::*;

   typedef struct packed {
      logic             clk_m;
      logic             clk_s;
      logic             clk_p;
      logic             dat_m;
      logic             dat_s;
      logic             dat_p;
      logic [EVT_N-1:0] tog;
      logic             sample;
   } sss_smp_t;

   sss_smp_t q;
   sss_smp_t next_q;

   // ---------------------------------------------------------------
   // Edge detection on synchronised lines
   // ---------------------------------------------------------------
   always_comb begin
      next_q       = q;
      next_q.clk_m = clock_line_in;
      next_q.clk_s = q.clk_m;
      next_q.clk_p = q.clk_s;
      next_q.dat_m = data_line_in;
      next_q.dat_s = q.dat_m;
      next_q.dat_p = q.dat_s;
      if (q.clk_s && !q.clk_p) begin
         next_q.sample            = q.dat_s;
         next_q.tog[EVT_RISE]     = ~q.tog[EVT_RISE];
      end
      if (!q.clk_s && q.clk_p) begin
         next_q.tog[EVT_FALL]     = ~q.tog[EVT_FALL];
      end
      if (q.clk_s && q.clk_p && !q.dat_s && q.dat_p) begin
         next_q.tog[EVT_COND1]    = ~q.tog[EVT_COND1];
      end
      if (q.clk_s && q.clk_p && q.dat_s && !q.dat_p) begin
         next_q.tog[EVT_COND2]    = ~q.tog[EVT_COND2];
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '{clk_m: RST_LEVEL, clk_s: RST_LEVEL, clk_p: RST_LEVEL,
                dat_m: RST_LEVEL, dat_s: RST_LEVEL, dat_p: RST_LEVEL,
                tog: '0, sample: RST_FLAG};
      end else begin
         q <= next_q;
      end
   end

   assign evt.evt_toggle  = q.tog;
   assign evt.sample_link = q.sample;
   assign evt.level_link  = {q.dat_s, q.clk_s};
endmodule

/* sss_evt_sync.sv */
// System-domain crossing of link events and line levels
`timescale 1ns/10ps
module sss_evt_sync (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic ce_in,
   sss_evt_if.sync   evt
);
   import sss_pkg::*;

   typedef struct packed {
      logic [EVT_N-1:0] t_m;
      logic [EVT_N-1:0] t_s;
      logic [EVT_N-1:0] t_p;
      logic [EVT_N-1:0] t_d;
      logic             smp_m;
      logic             smp_s;
      logic [1:0]       lvl_m;
      logic [1:0]       lvl_s;
   } sss_sync_t;

   sss_sync_t q;
   sss_sync_t next_q;

   // ---------------------------------------------------------------
   // Two-flop synchronisers, pulse one stage late so sample is settled
   // ---------------------------------------------------------------
   always_comb begin
      next_q       = q;
      next_q.t_m   = evt.evt_toggle;
      next_q.t_s   = q.t_m;
      next_q.t_p   = q.t_s;
      next_q.t_d   = q.t_p;
      next_q.smp_m = evt.sample_link;
      next_q.smp_s = q.smp_m;
      next_q.lvl_m = evt.level_link;
      next_q.lvl_s = q.lvl_m;
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '{t_m: '0, t_s: '0, t_p: '0, t_d: '0,
                smp_m: RST_FLAG, smp_s: RST_FLAG,
                lvl_m: {2{RST_LEVEL}}, lvl_s: {2{RST_LEVEL}}};
      end else if (ce_in) begin
         q <= next_q;
      end
   end

   for (genvar i = 0; i < EVT_N; i++) begin : g_pulse
      assign evt.evt_pulse[i] = ce_in & (q.t_p[i] ^ q.t_d[i]);
   end
   assign evt.sample_sys = q.smp_s;
   assign evt.level_sys  = q.lvl_s;
endmodule

/* sss_top.sv */
// Serial stretch and sample assist with Avalon-MM register slave
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - Enable hands both port lines to block
// - Enabled lines are open-drain, pull low only
// - Per-line pull-up bits switch internal pull-ups
// - Stretch enable holds clock low after fall
// - Stretching clock low sets stretch-active flag
// - Write to sample register releases the stretch
// - Conditional stretch after condition one seen
// - Clock rise captures data line level
// - Same rise sets the new-sample flag
// - Reading sample register clears new-sample flag
// - Data fall, clock high: condition one
// - Data rise, clock high: condition two
// - Line registers read back real pin levels
module sss_top (
   input  wire logic                        clk_in,
   input  wire logic                        arst_n_in,
   input  wire logic                        ce_in,
   input  wire logic                        link_clk_in,
   input  wire logic [sss_pkg::AVS_AW-1:0]  avs_address_in,
   input  wire logic                        avs_read_in,
   input  wire logic                        avs_write_in,
   input  wire logic [3:0]                  avs_byteenable_in,
   input  wire logic [sss_pkg::AVS_DW-1:0]  avs_writedata_in,
   output logic      [sss_pkg::AVS_DW-1:0]  avs_readdata_out,
   output logic                             avs_waitrequest_out,
   input  wire logic                        clock_line_in,
   output logic                             clock_line_out,
   output logic                             clock_line_oe_n_out,
   input  wire logic                        data_line_in,
   output logic                             data_line_out,
   output logic                             data_line_oe_n_out,
   output logic                             port_takeover_out,
   output logic [1:0]                       pullup_en_out,
   output logic                             irq_cond_one_out,
   output logic                             irq_cond_two_out
);
   import sss_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              serial_port_enable;
      logic              stretch_enable;
      logic              conditional_stretch_enable;
      logic              stretch_active_flag;
      logic              clock_write;
      logic              data_write;
      logic              condition_one_flag;
      logic              condition_two_flag;
      logic              sampled_data_bit;
      logic              new_sample_flag;
      logic [1:0]        port_b_pullup_bits;
      logic              ack;
      logic [AVS_DW-1:0] rdata;
      logic              irq_one;
      logic              irq_two;
   } sss_core_t;

   sss_core_t q;
   sss_core_t next_q;

   logic              req;
   logic              wr_now;
   logic              rd_now;
   logic              wr_low;
   logic [AVS_DW-1:0] rd_value;

   sss_evt_if evt ();

   // ---------------------------------------------------------------
   // Link-side sampling and crossing
   // ---------------------------------------------------------------
   sss_pin_sampler u_sampler (
      .link_clk_in   (link_clk_in),
      .arst_n_in     (arst_n_in),
      .clock_line_in (clock_line_in),
      .data_line_in  (data_line_in),
      .evt           (evt)
   );

   sss_evt_sync u_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .ce_in     (ce_in),
      .evt       (evt)
   );

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [AVS_AW-1:0] addr,
                                input logic [AVS_AW-1:0] ofs);
      hit = (addr == ofs);
   endfunction

   assign req    = avs_read_in | avs_write_in;
   assign wr_now = avs_write_in & q.ack;
   assign rd_now = avs_read_in & q.ack;
   assign wr_low = wr_now & avs_byteenable_in[0];

   // ---------------------------------------------------------------
   // Read data mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_value = '0;
      if (hit(avs_address_in, OFS_CONTROL)) begin
         rd_value[CTRL_ENABLE_POS]  = q.serial_port_enable;
         rd_value[CTRL_STRETCH_POS] = q.stretch_enable;
         rd_value[CTRL_CONDSTR_POS] = q.conditional_stretch_enable;
         rd_value[CTRL_ACTIVE_POS]  = q.stretch_active_flag;
      end
      if (hit(avs_address_in, OFS_CLOCK)) begin
         rd_value[LINE_BIT_POS] = evt.level_sys[0];
      end
      if (hit(avs_address_in, OFS_DATA)) begin
         rd_value[LINE_BIT_POS] = evt.level_sys[1];
      end
      if (hit(avs_address_in, OFS_COND_ONE)) begin
         rd_value[LINE_BIT_POS] = q.condition_one_flag;
      end
      if (hit(avs_address_in, OFS_COND_TWO)) begin
         rd_value[LINE_BIT_POS] = q.condition_two_flag;
      end
      if (hit(avs_address_in, OFS_SAMPLED)) begin
         rd_value[LINE_BIT_POS] = q.sampled_data_bit;
      end
      if (hit(avs_address_in, OFS_EDGE)) begin
         rd_value[LINE_BIT_POS] = q.new_sample_flag;
      end
      if (hit(avs_address_in, OFS_PULLUP)) begin
         rd_value[PULLUP_CLOCK_POS] = q.port_b_pullup_bits[0];
         rd_value[PULLUP_DATA_POS]  = q.port_b_pullup_bits[1];
      end
   end

   // ---------------------------------------------------------------
   // Next-state logic: bus effects first, hardware events win
   // ---------------------------------------------------------------
   always_comb begin
      next_q         = q;
      next_q.ack     = req & ~q.ack;
      next_q.irq_one = 1'b0;
      next_q.irq_two = 1'b0;
      if (req && !q.ack) begin
         next_q.rdata = rd_value;
      end
      if (wr_low && hit(avs_address_in, OFS_CONTROL)) begin
         next_q.serial_port_enable =
            avs_writedata_in[CTRL_ENABLE_POS];
         next_q.stretch_enable =
            avs_writedata_in[CTRL_STRETCH_POS];
         next_q.conditional_stretch_enable =
            avs_writedata_in[CTRL_CONDSTR_POS];
      end
      if (wr_low && hit(avs_address_in, OFS_CLOCK)) begin
         next_q.clock_write = avs_writedata_in[LINE_BIT_POS];
      end
      if (wr_low && hit(avs_address_in, OFS_DATA)) begin
         next_q.data_write = avs_writedata_in[LINE_BIT_POS];
      end
      if (wr_low && hit(avs_address_in, OFS_PULLUP)) begin
         next_q.port_b_pullup_bits =
            {avs_writedata_in[PULLUP_DATA_POS],
             avs_writedata_in[PULLUP_CLOCK_POS]};
      end
      if (wr_now && hit(avs_address_in, OFS_COND_ONE)) begin
         next_q.condition_one_flag = 1'b0;
      end
      if (wr_now && hit(avs_address_in, OFS_COND_TWO)) begin
         next_q.condition_two_flag = 1'b0;
      end
      if (wr_now && hit(avs_address_in, OFS_SAMPLED)) begin
         next_q.stretch_active_flag = 1'b0;
      end
      if (rd_now && hit(avs_address_in, OFS_SAMPLED)) begin
         next_q.new_sample_flag = 1'b0;
      end
      if (q.serial_port_enable) begin
         if (evt.evt_pulse[EVT_RISE]) begin
            next_q.sampled_data_bit = evt.sample_sys;
            next_q.new_sample_flag  = 1'b1;
         end
         if (evt.evt_pulse[EVT_COND1]) begin
            next_q.condition_one_flag = 1'b1;
            next_q.irq_one            = 1'b1;
         end
         if (evt.evt_pulse[EVT_COND2]) begin
            next_q.condition_two_flag = 1'b1;
            next_q.irq_two            = 1'b1;
         end
         if (evt.evt_pulse[EVT_FALL]) begin
            if (q.stretch_enable) begin
               next_q.stretch_active_flag = 1'b1;
            end
            if (q.conditional_stretch_enable && q.condition_one_flag) begin
               next_q.stretch_active_flag = 1'b1;
            end
         end
      end else begin
         next_q.stretch_active_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '{serial_port_enable: RST_FLAG,
                stretch_enable: RST_FLAG,
                conditional_stretch_enable: RST_FLAG,
                stretch_active_flag: RST_FLAG,
                clock_write: RST_LINE_WRITE,
                data_write: RST_LINE_WRITE,
                condition_one_flag: RST_FLAG,
                condition_two_flag: RST_FLAG,
                sampled_data_bit: RST_FLAG,
                new_sample_flag: RST_FLAG,
                port_b_pullup_bits: '0,
                ack: 1'b0,
                rdata: '0,
                irq_one: 1'b0,
                irq_two: 1'b0};
      end else if (ce_in) begin
         q <= next_q;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign avs_waitrequest_out = req & ~q.ack;
   assign avs_readdata_out    = q.rdata;

   assign port_takeover_out = q.serial_port_enable;
   assign pullup_en_out     = q.port_b_pullup_bits;

   assign clock_line_out = 1'b0;
   assign data_line_out  = 1'b0;
   assign clock_line_oe_n_out =
      ~(q.serial_port_enable & (~q.clock_write | q.stretch_active_flag));
   assign data_line_oe_n_out =
      ~(q.serial_port_enable & ~q.data_write);

   assign irq_cond_one_out = q.irq_one;
   assign irq_cond_two_out = q.irq_two;
endmodule

/* sss_partner.sv */
// Model of the external serial party sharing the two lines
`timescale 1ns/10ps
module sss_partner (
   input  wire logic clk_in,
   input  wire logic clock_oe_n_in,
   input  wire logic data_oe_n_in,
   output logic      clock_pin_out,
   output logic      data_pin_out
);
   logic pull_clk;
   logic pull_data;
   logic stuck = 1'b0;
   // Open-drain wires, pulled up when nobody pulls
   assign clock_pin_out = ~(pull_clk | ~clock_oe_n_in);
   assign data_pin_out  = ~(pull_data | ~data_oe_n_in);
   initial begin
      pull_clk  = 1'b0;
      pull_data = 1'b0;
   end
   task automatic hold(input int c);
      repeat (c) @(posedge clk_in);
   endtask
   task automatic lines(input logic pc, input logic pd);
      pull_clk  <= pc;
      pull_data <= pd;
      hold(20);
   endtask
   // Data moves only while clock is low; waits out a stretch
   task automatic send_bit(input logic b);
      int n;
      pull_clk <= 1'b1;
      hold(8);
      pull_data <= ~b;
      hold(8);
      pull_clk <= 1'b0;
      n = 0;
      while (clock_pin_out !== 1'b1 && n < 400) begin
         hold(1);
         n++;
      end
      if (n >= 400) stuck = 1'b1;
      hold(20);
   endtask
endmodule

/* sss_monitor.sv */
// Port checker for the serial stretch and sample assist
`timescale 1ns/10ps
module sss_monitor
   import sss_pkg::*;
(
   input wire logic                       clk_in,
   input wire logic                       arst_n_in,
   input wire logic [sss_pkg::AVS_AW-1:0] avs_address_in,
   input wire logic                       avs_read_in,
   input wire logic                       avs_write_in,
   input wire logic [3:0]                 avs_byteenable_in,
   input wire logic [sss_pkg::AVS_DW-1:0] avs_writedata_in,
   input wire logic                       avs_waitrequest_out,
   input wire logic                       clock_line_out,
   input wire logic                       clock_line_oe_n_out,
   input wire logic                       data_line_out,
   input wire logic                       data_line_oe_n_out,
   input wire logic                       port_takeover_out,
   input wire logic                       irq_cond_one_out,
   input wire logic                       irq_cond_two_out
);
   logic acc_wr;
   logic cw;
   assign acc_wr = avs_write_in && !avs_waitrequest_out;
   // Shadow of the written clock line bit
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cw <= 1'b1;
      end else if (acc_wr && avs_address_in == OFS_CLOCK
                   && avs_byteenable_in[0]) begin
         cw <= avs_writedata_in[0];
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_req_rise;
      (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in);
   endsequence
   sequence s_one_wait;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   sequence s_release_wr;
      acc_wr && avs_address_in == OFS_SAMPLED && cw;
   endsequence
   a_bus_one_wait: assert property (s_req_rise |-> s_one_wait)
      else $error("bus answer not after one wait cycle");
   a_stretch_hold: assert property (
      (!clock_line_oe_n_out && cw && port_takeover_out && !(acc_wr &&
      (avs_address_in == OFS_SAMPLED || avs_address_in == OFS_CONTROL)))
      |=> !clock_line_oe_n_out)
      else $error("clock stretch dropped without release");
   a_stretch_release: assert property (
      s_release_wr |=> clock_line_oe_n_out)
      else $error("clock stretch not released");
   a_irq_one_pulse: assert property (
      irq_cond_one_out |=> !irq_cond_one_out)
      else $error("condition one pulse too long");
   a_irq_two_pulse: assert property (
      irq_cond_two_out |=> !irq_cond_two_out)
      else $error("condition two pulse too long");
   a_irq_when_on: assert property (
      (irq_cond_one_out || irq_cond_two_out) |-> $past(port_takeover_out))
      else $error("condition pulse while port disabled");
   a_lines_released: assert property (
      !port_takeover_out |-> clock_line_oe_n_out && data_line_oe_n_out)
      else $error("line pulled while port disabled");
   a_drive_low_only: assert property (
      clock_line_out == 1'b0 && data_line_out == 1'b0)
      else $error("line driven high");
endmodule
bind sss_top sss_monitor u_mon (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_byteenable_in(avs_byteenable_in),
   .avs_writedata_in(avs_writedata_in),
   .avs_waitrequest_out(avs_waitrequest_out),
   .clock_line_out(clock_line_out), .clock_line_oe_n_out(clock_line_oe_n_out),
   .data_line_out(data_line_out), .data_line_oe_n_out(data_line_oe_n_out),
   .port_takeover_out(port_takeover_out),
   .irq_cond_one_out(irq_cond_one_out), .irq_cond_two_out(irq_cond_two_out));

/* tb_sss_top.sv */
// Self-checking bench for the serial stretch and sample assist
`timescale 1ns/10ps
module tb_sss_top;
   import sss_pkg::*;
   logic              clk_in;
   logic              arst_n_in;
   logic              link_clk_in;
   logic [AVS_AW-1:0] avs_address_in;
   logic              avs_read_in;
   logic              avs_write_in;
   logic [AVS_DW-1:0] avs_writedata_in;
   logic [AVS_DW-1:0] avs_readdata_out;
   logic              avs_waitrequest_out;
   logic              clock_pin;
   logic              data_pin;
   logic              clock_line_oe_n_out;
   logic              data_line_oe_n_out;
   logic              port_takeover_out;
   logic [1:0]        pullup_en_out;
   logic              irq_cond_one_out;
   logic              irq_cond_two_out;
   int                seen1 = 0;
   int                seen2 = 0;
   logic [31:0]       q;
   int                error_cnt;
   int                tests_run;
   sss_top DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
      .link_clk_in(link_clk_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_byteenable_in(4'hf), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .clock_line_in(clock_pin), .clock_line_out(),
      .clock_line_oe_n_out(clock_line_oe_n_out), .data_line_in(data_pin),
      .data_line_out(), .data_line_oe_n_out(data_line_oe_n_out),
      .port_takeover_out(port_takeover_out), .pullup_en_out(pullup_en_out),
      .irq_cond_one_out(irq_cond_one_out), .irq_cond_two_out(irq_cond_two_out));
   sss_partner u_far (.clk_in(clk_in), .clock_oe_n_in(clock_line_oe_n_out),
      .data_oe_n_in(data_line_oe_n_out), .clock_pin_out(clock_pin),
      .data_pin_out(data_pin));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #7;
      forever #40 link_clk_in = ~link_clk_in;
   end
   always @(posedge clk_in) begin
      if (irq_cond_one_out === 1'b1) seen1 <= seen1 + 1;
      if (irq_cond_two_out === 1'b1) seen2 <= seen2 + 1;
   end
   task automatic stop_test;
      if (u_far.stuck) error_cnt++;
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e,
                      input string m);
      tests_run++;
      if (got !== e) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // Avalon-MM master: hold until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk_in);
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_read_in      <= rd;
      avs_write_in     <= ~rd;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      q = avs_readdata_out;
      chk(32'(avs_waitrequest_out), 32'h0, "bus answer missing");
      if (avs_waitrequest_out !== 1'b0) stop_test();
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0);
      chk(q, e, "register read");
   endtask
   task automatic poll(input logic [4:0] a, input int p, input logic e);
      int n;
      n = 0;
      do begin
         bus(1'b1, a, 32'h0);
         n++;
      end while (q[p] !== e && n < 60);
      chk(32'(q[p]), 32'(e), "flag wait");
      if (q[p] !== e) stop_test();
   endtask
   task automatic t_reset;
      logic [4:0] z [7];
      z = '{OFS_CONTROL, OFS_COND_ONE, OFS_COND_TWO, OFS_SAMPLED, OFS_EDGE,
            OFS_PULLUP, 5'h02};
      foreach (z[i]) rd(z[i], 32'h0);
      rd(OFS_CLOCK, 32'h1);
      @(negedge clk_in);
      chk(32'(port_takeover_out), 32'h0, "port taken at reset");
      chk(32'(clock_line_oe_n_out), 32'h1, "clock pulled");
      chk(32'(data_line_oe_n_out), 32'h1, "data pulled");
   endtask
   task automatic t_pullup;
      logic [31:0] v [4];
      v = '{32'h10, 32'h20, 32'h30, 32'h0};
      foreach (v[i]) begin
         bus(1'b0, OFS_PULLUP, v[i]);
         rd(OFS_PULLUP, v[i]);
         chk(32'(pullup_en_out), 32'(v[i][5:4]), "pull-up enables");
      end
   endtask
   task automatic t_lines;
      bus(1'b0, OFS_DATA, 32'h0);
      @(negedge clk_in);
      chk(32'(data_line_oe_n_out), 32'h1, "data pulled while off");
      bus(1'b0, OFS_CONTROL, 32'h1);
      @(negedge clk_in);
      chk(32'(port_takeover_out), 32'h1, "port not taken");
      chk(32'(data_line_oe_n_out), 32'h0, "data not pulled");
      poll(OFS_DATA, LINE_BIT_POS, 1'b0);
      bus(1'b0, OFS_DATA, 32'h1);
      poll(OFS_DATA, LINE_BIT_POS, 1'b1);
      u_far.lines(1'b1, 1'b0);
      poll(OFS_CLOCK, LINE_BIT_POS, 1'b0);
      u_far.lines(1'b0, 1'b0);
   endtask
   task automatic t_sample;
      logic b [3];
      b = '{1'b0, 1'b1, 1'b0};
      poll(OFS_EDGE, 0, 1'b1);
      rd(OFS_SAMPLED, 32'h1);
      rd(OFS_EDGE, 32'h0);
      foreach (b[i]) begin
         u_far.send_bit(b[i]);
         poll(OFS_EDGE, 0, 1'b1);
         rd(OFS_SAMPLED, 32'(b[i]));
         rd(OFS_EDGE, 32'h0);
      end
      u_far.send_bit(1'b1);
      u_far.send_bit(1'b0);
      rd(OFS_EDGE, 32'h1);
      rd(OFS_SAMPLED, 32'h0);
   endtask
   task automatic t_cond;
      bus(1'b0, OFS_COND_ONE, 32'h0);
      bus(1'b0, OFS_COND_TWO, 32'h0);
      u_far.lines(1'b0, 1'b0);
      poll(OFS_COND_TWO, 0, 1'b1);
      chk(32'(seen2), 32'h2, "condition two pulses");
      bus(1'b0, OFS_COND_TWO, 32'h0);
      rd(OFS_COND_TWO, 32'h0);
      u_far.lines(1'b0, 1'b1);
      poll(OFS_COND_ONE, 0, 1'b1);
      chk(32'(seen1), 32'h2, "condition one pulses");
      bus(1'b0, OFS_COND_ONE, 32'h0);
      rd(OFS_COND_ONE, 32'h0);
      bus(1'b0, OFS_CONTROL, 32'h0);
      u_far.lines(1'b0, 1'b0);
      u_far.lines(1'b0, 1'b1);
      rd(OFS_COND_ONE, 32'h0);
      rd(OFS_COND_TWO, 32'h0);
      u_far.lines(1'b0, 1'b0);
      chk(32'(seen1 + seen2), 32'h4, "pulse while off");
   endtask
   task automatic t_stretch(input logic [31:0] c, input logic b);
      fork
         u_far.send_bit(b);
         begin
            poll(OFS_CONTROL, CTRL_ACTIVE_POS, 1'b1);
            chk(32'(clock_line_oe_n_out), 32'h0, "clock free");
            rd(OFS_CLOCK, 32'h0);
            rd(OFS_EDGE, 32'h0);
            bus(1'b0, OFS_SAMPLED, 32'h0);
            @(negedge clk_in);
            chk(32'(clock_line_oe_n_out), 32'h1, "clock still held");
            rd(OFS_CONTROL, c);
         end
      join
      poll(OFS_EDGE, 0, 1'b1);
      rd(OFS_SAMPLED, 32'(b));
   endtask
   task automatic t_condstretch;
      bus(1'b0, OFS_CONTROL, 32'h5);
      u_far.send_bit(1'b1);
      rd(OFS_CONTROL, 32'h5);
      rd(OFS_SAMPLED, 32'h1);
      u_far.lines(1'b0, 1'b1);
      poll(OFS_COND_ONE, 0, 1'b1);
      t_stretch(32'h5, 1'b0);
   endtask
   initial begin
      arst_n_in        = 1'b0;
      avs_address_in   = '0;
      avs_read_in      = 1'b0;
      avs_write_in     = 1'b0;
      avs_writedata_in = '0;
      error_cnt        = 0;
      tests_run        = 0;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_pullup();
      t_lines();
      t_sample();
      t_cond();
      bus(1'b0, OFS_CONTROL, 32'h3);
      t_stretch(32'h3, 1'b1);
      t_condstretch();
      stop_test();
   end
endmodule
